// File: psrm_pkg.sv
// package of constants and carriers for the payload shutdown / reset manager
// assumes a single 40 MHz core clock; all event inputs except bios_running are synchronous one-cycle pulses
// Summary of operation
// - shutdown request pulses the power button line toward the payload
// - handle-open event or management shutdown command both start graceful shutdown
// - no sleep indication within 60 s of shutdown start removes payload power
// - boot watchdog expiry during bios execution swaps to the other bios flash
// - management watchdog is enabled straight out of reset
// - firmware watchdog resets the controller unless the main task restarts it
// - firmware watchdog bite isolates the ipmb, payload state untouched
// - management cold reset returns all state except the reset button tracking to power-up defaults
// - cold reset at power-on, held while management power is low
// - reset button held over five seconds gives management cold reset
// - reset button press under five seconds gives payload cold reset only
// - software cold reset command acts like power-on cold reset except that the reset button tracking is kept
// - warm reset restores the watchdog enable default but keeps address and enable settings
// - payload power activation after hot swap change issues payload cold reset
// - fru control cold reset or chassis power command gives payload cold reset
// - management watchdog expiry gives payload cold reset
package psrm_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SHDN_TMO_S      = 60;
  localparam int unsigned LONG_PRESS_S    = 5;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned PWRBTN_MS       = 200;
  localparam int unsigned RST_PULSE_US    = 100;
  localparam int unsigned SHDN_TMO_CYC    = SHDN_TMO_S * CLK_HZ;
  localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRBTN_CYC      = PWRBTN_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_PULSE_CYC   = RST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FW_WDT_CYC      = 2 * CLK_HZ;
  localparam logic        FLASH_SEL_RST   = 1'b0;
  localparam logic [7:0]  MGMT_ADDR_RST   = 8'h00;
  localparam logic        MGMT_EN_RST     = 1'b1;
  localparam logic        WDT_EN_RST      = 1'b1;

  typedef enum logic [1:0] {
    PSRM_SD_IDLE  = 2'b00,
    PSRM_SD_BTN   = 2'b01,
    PSRM_SD_WAIT  = 2'b10,
    PSRM_SD_OFF   = 2'b11
  } psrm_sd_e;

  typedef struct packed {
    logic handle_open;
    logic shdn_cmd;
    logic sw_cold_cmd;
    logic sw_warm_cmd;
    logic fru_cold_cmd;
    logic chassis_cmd;
    logic fw_wdt_kick;
    logic wdt_expire;
    logic bios_running;
    logic pwr_activate;
  } psrm_evt_s;

  typedef struct packed {
    logic pwr_btn;
    logic payload_pwr_en;
    logic payload_rst;
    logic flash_sel;
    logic shdn_timeout;
  } psrm_pl_s;

  typedef struct packed {
    logic       cold_rst;
    logic       warm_rst;
    logic       ipmb_isolate;
    logic       wdt_en;
    logic [7:0] addr;
    logic       enable;
  } psrm_mg_s;
endpackage

// File: psrm_pulse_timer.sv
// counting timer: start loads a count, done pulses when it reaches the end
// assumes synchronous start/stop pulses in the core clock domain
`timescale 1ns/1ps
`default_nettype none
module psrm_pulse_timer #(
  parameter int unsigned W   = 32,
  parameter int unsigned CYC = 100
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic stop,
  output logic      busy,
  output logic      done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;
  logic         done_d;
  logic         done_q;

  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = W'(CYC - 1);
      run_d = 1'b1;
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign busy = run_q;
  assign done = done_q;
endmodule
`default_nettype wire

// File: psrm_top.sv
// payload shutdown, bios failover and reset sourcing for the management side
// assumes synchronous single-cycle event pulses and an already synchronised button level
`timescale 1ns/1ps
`default_nettype none
module psrm_top
  import psrm_pkg::*;
#(
  parameter int unsigned SHDN_CYC  = SHDN_TMO_CYC,
  parameter int unsigned LONG_CYC  = LONG_PRESS_CYC,
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned BTN_CYC   = PWRBTN_CYC,
  parameter int unsigned FWWDT_CYC = FW_WDT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       mgmt_pwr_good,
  input  wire psrm_evt_s  evt,
  input  wire logic       rst_button,
  input  wire logic       sleep_ind,
  input  wire logic       wdt_en_cmd,
  input  wire logic       wdt_en_val,
  input  wire logic       addr_wr,
  input  wire logic [7:0] addr_val,
  output psrm_pl_s        pl,
  output psrm_mg_s        mg
);
  // full cold reset: power-on, low management power, or cold request from inside
  logic cold_req;
  logic cold_q;
  logic cold_d;
  logic rst_all;
  logic rst_pwr;
  assign rst_all = reset | ~mgmt_pwr_good | cold_q;
  // button tracking survives the cold pulse that a long press itself raises
  assign rst_pwr = reset | ~mgmt_pwr_good;

  // ---------------- button debounce and press classification ----------------
  logic btn_q;
  logic btn_d;
  logic btn_long_done;
  logic btn_long_q;
  logic btn_long_d;
  logic btn_chg;
  logic btn_deb_done;
  logic long_press_evt;
  logic short_press_evt;
  logic deb_busy;

  assign btn_chg = (rst_button != btn_q);

  psrm_pulse_timer #(.W(32), .CYC(DEB_CYC)) u_deb (
    .core_clk (core_clk),
    .reset    (rst_pwr),
    .start    (btn_chg & ~deb_busy),
    .stop     (~btn_chg & deb_busy),
    .busy     (deb_busy),
    .done     (btn_deb_done)
  );

  psrm_pulse_timer #(.W(32), .CYC(LONG_CYC)) u_long (
    .core_clk (core_clk),
    .reset    (rst_pwr),
    .start    (btn_deb_done & ~btn_q),
    .stop     (btn_deb_done & btn_q),
    .busy     (),
    .done     (btn_long_done)
  );

  always_comb begin
    btn_d           = btn_q;
    btn_long_d      = btn_long_q;
    long_press_evt  = 1'b0;
    short_press_evt = 1'b0;
    if (btn_deb_done) begin
      btn_d = ~btn_q;
      if (btn_q && !btn_long_q) begin
        short_press_evt = 1'b1;
      end
      if (btn_q) begin
        btn_long_d = 1'b0;
      end
    end
    if (btn_long_done && btn_q) begin
      btn_long_d     = 1'b1;
      long_press_evt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_pwr) begin
      btn_q      <= 1'b0;
      btn_long_q <= 1'b0;
    end else begin
      btn_q      <= btn_d;
      btn_long_q <= btn_long_d;
    end
  end

  // ---------------- firmware watchdog ----------------
  logic fw_bite;
  logic fw_busy;
  psrm_pulse_timer #(.W(32), .CYC(FWWDT_CYC)) u_fwwdt (
    .core_clk (core_clk),
    .reset    (rst_all),
    .start    (evt.fw_wdt_kick | ~fw_busy),
    .stop     (1'b0),
    .busy     (fw_busy),
    .done     (fw_bite)
  );

  // ---------------- graceful shutdown sequencer ----------------
  psrm_sd_e sd_q;
  psrm_sd_e sd_d;
  logic     shdn_req;
  logic     btn_tmr_start;
  logic     btn_tmr_busy;
  logic     btn_tmr_done;
  logic     tmo_start;
  logic     tmo_stop;
  logic     tmo_done;
  logic     pwr_en_q;
  logic     pwr_en_d;
  logic     tmo_flag_q;
  logic     tmo_flag_d;

  assign shdn_req = evt.handle_open | evt.shdn_cmd;

  psrm_pulse_timer #(.W(8 + 24), .CYC(BTN_CYC)) u_pbtn (
    .core_clk (core_clk),
    .reset    (rst_all),
    .start    (btn_tmr_start),
    .stop     (1'b0),
    .busy     (btn_tmr_busy),
    .done     (btn_tmr_done)
  );

  psrm_pulse_timer #(.W(32), .CYC(SHDN_CYC)) u_tmo (
    .core_clk (core_clk),
    .reset    (rst_all),
    .start    (tmo_start),
    .stop     (tmo_stop),
    .busy     (),
    .done     (tmo_done)
  );

  always_comb begin
    sd_d          = sd_q;
    pwr_en_d      = pwr_en_q;
    tmo_flag_d    = tmo_flag_q;
    btn_tmr_start = 1'b0;
    tmo_start     = 1'b0;
    tmo_stop      = 1'b0;
    case (sd_q)
      PSRM_SD_IDLE: begin
        if (shdn_req && pwr_en_q) begin
          btn_tmr_start = 1'b1;
          tmo_start     = 1'b1;
          tmo_flag_d    = 1'b0;
          sd_d          = PSRM_SD_BTN;
        end
      end
      PSRM_SD_BTN: begin
        // further requests fall through unheeded here
        if (sleep_ind) begin
          tmo_stop = 1'b1;
          pwr_en_d = 1'b0;
          sd_d     = PSRM_SD_OFF;
        end else if (btn_tmr_done) begin
          sd_d = PSRM_SD_WAIT;
        end
      end
      PSRM_SD_WAIT: begin
        if (sleep_ind) begin
          tmo_stop = 1'b1;
          pwr_en_d = 1'b0;
          sd_d     = PSRM_SD_OFF;
        end else if (tmo_done) begin
          tmo_flag_d = 1'b1;
          pwr_en_d   = 1'b0;
          sd_d       = PSRM_SD_OFF;
        end
      end
      PSRM_SD_OFF: begin
        // power already dropped on entry; wait for the button pulse to end
        if (!btn_tmr_busy) begin
          sd_d = PSRM_SD_IDLE;
        end
      end
      default: sd_d = PSRM_SD_IDLE;
    endcase
    // activation wins over a power drop in the same cycle
    if (evt.pwr_activate) begin
      pwr_en_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      sd_q       <= PSRM_SD_IDLE;
      pwr_en_q   <= 1'b1;
      tmo_flag_q <= 1'b0;
    end else begin
      sd_q       <= sd_d;
      pwr_en_q   <= pwr_en_d;
      tmo_flag_q <= tmo_flag_d;
    end
  end

  // ---------------- bios failover, watchdog enable, payload reset ----------------
  logic       flash_q;
  logic       flash_d;
  logic       wdt_en_q;
  logic       wdt_en_d;
  logic       iso_q;
  logic       iso_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic       en_q;
  logic       en_d;
  logic       warm_q;
  logic       warm_d;
  logic       pl_rst_req;
  logic       pl_rst_busy;
  logic       wdt_fire;

  assign wdt_fire   = evt.wdt_expire & wdt_en_q;
  assign pl_rst_req = (evt.pwr_activate & ~pwr_en_q)
                    | short_press_evt
                    | evt.fru_cold_cmd | evt.chassis_cmd
                    | wdt_fire;
  assign cold_req   = long_press_evt | evt.sw_cold_cmd;

  psrm_pulse_timer #(.W(32), .CYC(RST_PULSE_CYC)) u_plrst (
    .core_clk (core_clk),
    .reset    (rst_all),
    .start    (pl_rst_req),
    .stop     (1'b0),
    .busy     (pl_rst_busy),
    .done     ()
  );

  always_comb begin
    flash_d  = flash_q;
    wdt_en_d = wdt_en_q;
    iso_d    = iso_q | fw_bite;
    addr_d   = addr_q;
    en_d     = en_q;
    warm_d   = evt.sw_warm_cmd | fw_bite;
    cold_d   = cold_req;
    if (wdt_fire && evt.bios_running) begin
      flash_d = ~flash_q;
    end
    if (wdt_en_cmd) begin
      wdt_en_d = wdt_en_val;
    end
    if (addr_wr) begin
      addr_d = addr_val;
    end
    if (warm_q) begin
      // watchdog enable default back, address and enable kept
      wdt_en_d = WDT_EN_RST;
    end
  end

  // cold pulse register: cleared only at power-on or while management power is low
  always_ff @(posedge core_clk) begin
    if (reset | ~mgmt_pwr_good) begin
      cold_q <= 1'b0;
    end else begin
      cold_q <= cold_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      flash_q  <= FLASH_SEL_RST;
      wdt_en_q <= WDT_EN_RST;
      iso_q    <= 1'b0;
      addr_q   <= MGMT_ADDR_RST;
      en_q     <= MGMT_EN_RST;
      warm_q   <= 1'b0;
    end else begin
      flash_q  <= flash_d;
      wdt_en_q <= wdt_en_d;
      iso_q    <= iso_d;
      addr_q   <= addr_d;
      en_q     <= en_d;
      warm_q   <= warm_d;
    end
  end

  assign pl.pwr_btn        = btn_tmr_busy;
  assign pl.payload_pwr_en = pwr_en_q;
  assign pl.payload_rst    = pl_rst_busy;
  assign pl.flash_sel      = flash_q;
  assign pl.shdn_timeout   = tmo_flag_q;
  assign mg.cold_rst       = rst_all;
  assign mg.warm_rst       = warm_q;
  assign mg.ipmb_isolate   = iso_q;
  assign mg.wdt_en         = wdt_en_q;
  assign mg.addr           = addr_q;
  assign mg.enable         = en_q;
endmodule
`default_nettype wire

// File: psrm_sva.sv
// concurrent checks on the ports of psrm_top
// assumes a single core clock; bound into psrm_top below
`timescale 1ns/1ps
`default_nettype none
module psrm_sva
  import psrm_pkg::*;
#(
  parameter int unsigned BTN_CYC = 8
) (
  input wire logic      core_clk,
  input wire logic      reset,
  input wire logic      mgmt_pwr_good,
  input wire psrm_evt_s evt,
  input wire psrm_pl_s  pl,
  input wire psrm_mg_s  mg
);
  logic [31:0] btn_cnt_q;
  logic [31:0] btn_cnt_d;
  // length of the current power-button pulse
  always_comb btn_cnt_d = pl.pwr_btn ? btn_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge core_clk) btn_cnt_q <= mg.cold_rst ? 32'h0 : btn_cnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (mg.cold_rst);
  btn_cause_a: assert property ($rose(pl.pwr_btn) |->
    $past(evt.shdn_cmd || evt.handle_open, 1)) else $error("power button without request");
  btn_width_a: assert property ($fell(pl.pwr_btn) |-> btn_cnt_q == BTN_CYC)
    else $error("power button pulse length wrong");
  flash_swap_a: assert property (evt.wdt_expire && evt.bios_running && mg.wdt_en |=>
    pl.flash_sel != $past(pl.flash_sel)) else $error("bios flash not swapped");
  rst_cmd_a: assert property (evt.fru_cold_cmd || evt.chassis_cmd |-> ##2 pl.payload_rst)
    else $error("payload reset missing after command");
  rst_wdt_a: assert property (evt.wdt_expire && mg.wdt_en |-> ##2 pl.payload_rst)
    else $error("payload reset missing after watchdog");
  tmo_off_a: assert property ($rose(pl.shdn_timeout) |-> ##[0:1] !pl.payload_pwr_en)
    else $error("power kept after shutdown timeout");
  sw_cold_a: assert property (disable iff (reset) evt.sw_cold_cmd |=> mg.cold_rst)
    else $error("cold reset command ignored");
  pwr_cold_a: assert property (disable iff (reset) !mgmt_pwr_good |-> mg.cold_rst)
    else $error("no cold reset with low power");
  ipmb_keep_a: assert property ($rose(mg.ipmb_isolate) |->
    $stable(pl.payload_pwr_en) && $stable(pl.flash_sel)) else $error("payload disturbed");
  cover property (pl.shdn_timeout);
  cover property ($rose(mg.ipmb_isolate));
  cover property (evt.wdt_expire && evt.bios_running && mg.wdt_en);
endmodule
bind psrm_top psrm_sva #(.BTN_CYC(BTN_CYC)) i_psrm_sva (.core_clk(core_clk), .reset(reset),
  .mgmt_pwr_good(mgmt_pwr_good), .evt(evt), .pl(pl), .mg(mg));
`default_nettype wire

// File: psrm_payload_model.sv
// behavioural payload answering the power button with a sleep indication
// assumes mode 0 prompt, 1 slow, 2 never answers
`timescale 1ns/1ps
`default_nettype none
module psrm_payload_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] mode,
  input  wire logic       pwr_btn,
  input  wire logic       pwr_en,
  output logic            sleep_ind
);
  int   cnt_q = -1;
  logic btn_q = 1'b0;
  logic pwr_q = 1'b1;
  initial sleep_ind = 1'b0;
  always @(posedge core_clk) begin
    btn_q <= pwr_btn;
    pwr_q <= pwr_en;
    if (pwr_btn && !btn_q && mode != 2'h2) cnt_q <= (mode == 2'h0) ? 3 : 40;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    // os done: report sleep until power comes back
    if (cnt_q == 0) begin
      sleep_ind <= 1'b1;
      cnt_q <= -1;
    end
    if (pwr_en && !pwr_q) sleep_ind <= 1'b0;
  end
endmodule
`default_nettype wire

// File: tb_psrm_top.sv
// self-checking bench for psrm_top with a behavioural payload
// assumes psrm_pkg, psrm_top, psrm_sva and psrm_payload_model compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_psrm_top
  import psrm_pkg::*;
;
  localparam int SD = 200, LP = 200, DB = 4, BT = 8, FW = 100;
  localparam psrm_evt_s HOP = '{handle_open: 1'b1, default: 1'b0};
  localparam psrm_evt_s SHD = '{shdn_cmd: 1'b1, default: 1'b0};
  localparam psrm_evt_s CLD = '{sw_cold_cmd: 1'b1, default: 1'b0};
  localparam psrm_evt_s WRM = '{sw_warm_cmd: 1'b1, default: 1'b0};
  localparam psrm_evt_s FRU = '{fru_cold_cmd: 1'b1, default: 1'b0};
  localparam psrm_evt_s CHS = '{chassis_cmd: 1'b1, default: 1'b0};
  localparam psrm_evt_s EXP = '{wdt_expire: 1'b1, default: 1'b0};
  localparam psrm_evt_s ACT = '{pwr_activate: 1'b1, default: 1'b0};
  logic       core_clk = 1'b0, reset = 1'b1, pwr_good = 1'b1, rst_button = 1'b0;
  logic       kick_en = 1'b1, kick = 1'b0, bios = 1'b0, wen_cmd = 1'b0, wen_val = 1'b1;
  logic       addr_wr = 1'b0, rst_q = 1'b0, sleep_ind;
  logic [7:0] addr_val = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [31:0] seed = 32'h5;
  psrm_evt_s  ev = '0, evt_w;
  psrm_pl_s   pl;
  psrm_mg_s   mg;
  int         failures = 0, num_checks = 0, rst_rises = 0, cold_seen = 0, cycles = 0;
  psrm_top #(.SHDN_CYC(SD), .LONG_CYC(LP), .DEB_CYC(DB), .BTN_CYC(BT), .FWWDT_CYC(FW)) i_psrm_top (
    .core_clk(core_clk), .reset(reset), .mgmt_pwr_good(pwr_good), .evt(evt_w),
    .rst_button(rst_button), .sleep_ind(sleep_ind), .wdt_en_cmd(wen_cmd), .wdt_en_val(wen_val),
    .addr_wr(addr_wr), .addr_val(addr_val), .pl(pl), .mg(mg));
  psrm_payload_model i_psrm_payload_model (.core_clk(core_clk), .mode(mode),
    .pwr_btn(pl.pwr_btn), .pwr_en(pl.payload_pwr_en), .sleep_ind(sleep_ind));
  always_comb begin
    evt_w = ev;
    evt_w.fw_wdt_kick = kick;
    evt_w.bios_running = bios;
  end
  initial forever #12.5 core_clk = ~core_clk;
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // event counters and the firmware watchdog kicker
  always @(posedge core_clk) begin
    rst_q <= pl.payload_rst;
    if (pl.payload_rst && !rst_q) rst_rises++;
    if (mg.cold_rst && !reset) cold_seen++;
    cycles++;
    kick <= (cycles % 40 == 0) && kick_en;
    if (cycles > 80000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input psrm_evt_s m);
    @(posedge core_clk);
    ev <= ev | m;
    @(posedge core_clk);
    ev <= ev & ~m;
  endtask
  task automatic press(input int n);
    @(posedge core_clk);
    rst_button <= 1'b1;
    cyc(n);
    rst_button <= 1'b0;
  endtask
  task automatic wen(input logic v);
    @(posedge core_clk);
    wen_cmd <= 1'b1;
    wen_val <= v;
    @(posedge core_clk);
    wen_cmd <= 1'b0;
  endtask
  task automatic rst_idle();
    #1;
    for (int i = 0; i < RST_PULSE_CYC + 9 && pl.payload_rst !== 1'b0; i++) begin
      cyc(1);
      #1;
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial begin
    int          w, rr, cs;
    logic [31:0] r;
    logic        exp_fl, exp_we;
    cyc(8);
    reset <= 1'b0;
    cyc(1);
    #1 `CHK(pl.payload_pwr_en, 1'b1)
    `CHK(pl.flash_sel, FLASH_SEL_RST)
    `CHK(mg.wdt_en, WDT_EN_RST)
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      rst_idle();
      pulse(m == 1 ? HOP : SHD);
      cyc(2);
      #1 `CHK(pl.pwr_btn, 1'b1)
      pulse(SHD);
      w = 0;
      while (pl.payload_pwr_en === 1'b1 && w < SD + 50) begin
        cyc(1);
        #1 w++;
      end
      `CHK(pl.payload_pwr_en, 1'b0)
      `CHK(pl.shdn_timeout, m == 2)
      `CHK(w >= SD - 10, m == 2)
      rr = rst_rises;
      pulse(ACT);
      cyc(3);
      #1 `CHK(pl.payload_pwr_en, 1'b1)
      `CHK(rst_rises - rr, 1)
    end
    exp_fl = FLASH_SEL_RST;
    exp_we = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = xs();
      if (r[1]) begin
        wen(r[2]);
        exp_we = r[2];
      end
      @(posedge core_clk);
      bios <= r[0];
      pulse(EXP);
      if (r[0] && exp_we) exp_fl = ~exp_fl;
      #1 `CHK(pl.flash_sel, exp_fl)
      `CHK(mg.wdt_en, exp_we)
    end
    wen(1'b1);
    bios <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rst_idle();
      rr = rst_rises;
      pulse(k == 0 ? FRU : k == 1 ? CHS : EXP);
      cyc(3);
      #1 `CHK(rst_rises - rr, 1)
    end
    rst_idle();
    rr = rst_rises;
    cs = cold_seen;
    press(DB - 2);
    cyc(20);
    `CHK(rst_rises - rr, 0)
    press(DB + 20);
    cyc(20);
    `CHK(rst_rises - rr, 1)
    `CHK(cold_seen - cs, 0)
    rst_idle();
    rr = rst_rises;
    press(LP + DB + 40);
    cyc(20);
    `CHK(cold_seen > cs, 1'b1)
    `CHK(rst_rises - rr, 0)
    r = xs();
    @(posedge core_clk);
    addr_wr <= 1'b1;
    addr_val <= r[7:0];
    @(posedge core_clk);
    addr_wr <= 1'b0;
    wen(1'b0);
    pulse(WRM);
    #1 `CHK(mg.warm_rst, 1'b1)
    cyc(2);
    #1 `CHK(mg.addr, r[7:0])
    `CHK(mg.enable, MGMT_EN_RST)
    `CHK(mg.wdt_en, WDT_EN_RST)
    wen(1'b0);
    pulse(CLD);
    #1 `CHK(mg.cold_rst, 1'b1)
    cyc(2);
    #1 `CHK(mg.wdt_en, WDT_EN_RST)
    `CHK(mg.addr, MGMT_ADDR_RST)
    kick_en <= 1'b0;
    cyc(FW + 50);
    #1 `CHK(mg.ipmb_isolate, 1'b1)
    `CHK(pl.payload_pwr_en, 1'b1)
    kick_en <= 1'b1;
    @(posedge core_clk);
    pwr_good <= 1'b0;
    cyc(3);
    #1 `CHK(mg.cold_rst, 1'b1)
    @(posedge core_clk);
    pwr_good <= 1'b1;
    cyc(2);
    #1 `CHK(mg.ipmb_isolate, 1'b0)
    `CHK(mg.cold_rst, 1'b0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
